// file: t1_alarm_pkg.sv
package t1_alarm_pkg;

  // Register addresses on the parallel control port
  localparam logic [7:0] LINE_ALARM_STATUS_ADDR = 8'h20;
  localparam logic [7:0] EVENT_STATUS_ADDR      = 8'h21;
  localparam logic [7:0] LINE_MASK_ADDR         = 8'h7F;
  localparam logic [7:0] EVENT_MASK_ADDR        = 8'h6F;
  localparam logic [7:0] MASK_RESET             = 8'h00;
  localparam logic [7:0] RDATA_UNMAPPED         = 8'h00;

  // Bit positions in line_alarm_status
  localparam int unsigned LUP_BIT  = 7;
  localparam int unsigned LDN_BIT  = 6;
  localparam int unsigned TX_CLOCK_LOST_BIT = 5;
  localparam int unsigned SLIP_BIT = 4;
  // Bits 3..0 are the four alarms whose every change interrupts
  localparam logic [7:0]  ALARM_BITS = 8'h0F;

  // Transmit clock loss: one channel time
  localparam int unsigned REF_CLK_PERIOD_NS  = 10;
  localparam int unsigned TXCLK_LOSS_NS      = 5200;
  localparam int unsigned TXCLK_LOSS_CYCLES  = TXCLK_LOSS_NS / REF_CLK_PERIOD_NS;

  // Receive timing in line bits at the T1 rate
  localparam int unsigned T1_BITS_PER_MS     = 1544;
  localparam int unsigned BLUE_WINDOW_MS     = 3;
  localparam int unsigned SEC_SHORT_MS       = 999;
  localparam int unsigned SEC_LONG_MS        = 1002;
  localparam int unsigned BLUE_WINDOW_BITS_DEF = T1_BITS_PER_MS * BLUE_WINDOW_MS;
  localparam int unsigned SEC_SHORT_BITS_DEF   = T1_BITS_PER_MS * SEC_SHORT_MS;
  localparam int unsigned SEC_LONG_BITS_DEF    = T1_BITS_PER_MS * SEC_LONG_MS;

  // Alarm thresholds
  localparam int unsigned BLUE_SET_MAX_ZEROS = 5;
  localparam int unsigned RED_SET_ZEROS      = 192;
  localparam int unsigned RED_CLEAR_WINDOW   = 112;
  localparam int unsigned RED_CLEAR_ONES     = 14;
  localparam int unsigned YEL_WINDOW         = 256;
  localparam int unsigned YEL_MIN_ZEROS      = 254;
  localparam int unsigned ESF_SET_RUN        = 16;
  localparam int unsigned ESF_CLEAR_MAX      = 14;
  localparam int unsigned FDL_BYTE_BITS      = 8;
  localparam int unsigned ABORT_ONES         = 8;
  localparam int unsigned T1_CHANNELS        = 24;

  // One-second tick phase: two short seconds then one long
  typedef enum logic [1:0] {
    SEC_FIRST  = 2'b00,
    SEC_SECOND = 2'b01,
    SEC_THIRD  = 2'b10
  } sec_phase_e;

endpackage

// file: t1_alarm_status_flags.sv
module t1_alarm_status_flags #(
  parameter int unsigned BLUE_WINDOW_BITS = t1_alarm_pkg::BLUE_WINDOW_BITS_DEF,
  parameter int unsigned SEC_SHORT_BITS   = t1_alarm_pkg::SEC_SHORT_BITS_DEF,
  parameter int unsigned SEC_LONG_BITS    = t1_alarm_pkg::SEC_LONG_BITS_DEF
) (
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] cpu_addr,
  input  wire logic       cpu_rd,
  input  wire logic       cpu_wr,
  input  wire logic [7:0] cpu_wdata,
  output logic      [7:0] cpu_rdata,
  output logic            int_n,
  input  wire logic       rx_bit_en,
  input  wire logic       rx_positive_rail_in,
  input  wire logic       rx_negative_rail_in,
  input  wire logic       framer_in_sync,
  input  wire logic       slip_event,
  input  wire logic       rx_mf_boundary,
  input  wire logic       tx_mf_boundary,
  input  wire logic       loop_up_match,
  input  wire logic       loop_down_match,
  input  wire logic       tx_clock_in,
  input  wire logic       loss_pin_select,
  input  wire logic       tx_clock_fallback_enable,
  input  wire logic       yellow_mode_select,
  input  wire logic       esf_mode,
  input  wire logic       chan_bit_en,
  input  wire logic       chan_bit2,
  input  wire logic       chan_sig_en,
  input  wire logic [4:0] chan_index,
  input  wire logic [3:0] chan_sig,
  input  wire logic       fbit12_en,
  input  wire logic       fbit12,
  input  wire logic       fdl_bit_en,
  input  wire logic       fdl_bit,
  input  wire logic       fdl_pattern_en,
  input  wire logic       fdl_pattern_00ff,
  input  wire logic [7:0] link_match_reg_a,
  input  wire logic [7:0] link_match_reg_b,
  input  wire logic       tx_link_drained,
  output logic            loss_indicator_pin,
  output logic            tx_clock_use_recovered
);
  import t1_alarm_pkg::*;

  // Detector state
  logic        txclk_q, txclk_d;
  logic [9:0]  txcnt_q, txcnt_d;
  logic [7:0]  zrun_q, zrun_d;
  logic        red_q, red_d;
  logic        rclr_q, rclr_d;
  logic [6:0]  rpos_q, rpos_d;
  logic [4:0]  rones_q, rones_d;
  logic [12:0] bwin_q, bwin_d;
  logic [2:0]  bzero_q, bzero_d;
  logic        blue_q, blue_d;
  logic        yel_q, yel_d;
  logic [7:0]  ycnt_q, ycnt_d;
  logic [8:0]  yzero_q, yzero_d;
  logic [1:0]  fhist_q, fhist_d;
  logic [4:0]  erun_q, erun_d;
  logic [3:0]  eblk_q, eblk_d;
  logic [4:0]  ehits_q, ehits_d;
  logic [20:0] scnt_q, scnt_d;
  sec_phase_e  sphase_q, sphase_d;
  logic        tick_q, tick_d;
  logic [7:0]  fsh_q, fsh_d;
  logic [2:0]  fnum_q, fnum_d;
  logic [3:0]  fones_q, fones_d;
  logic        ffull_q, ffull_d;
  logic        fmatch_q, fmatch_d;
  logic        fabort_q, fabort_d;
  logic        sigchg_q, sigchg_d;
  logic [T1_CHANNELS-1:0] sseen_q, sseen_d;
  logic [3:0]  sig_mem [T1_CHANNELS];
  logic        sig_we;

  logic        bit_one;
  logic        tx_clock_lost;
  logic [7:0]  byte_now;
  logic [20:0] sec_limit;

  assign bit_one = rx_positive_rail_in | rx_negative_rail_in;

  // Line alarms, tick, link and signaling detectors
  always_comb begin
    txclk_d = tx_clock_in;
    txcnt_d = txcnt_q;
    zrun_d = zrun_q;  red_d = red_q;  rclr_d = rclr_q;
    rpos_d = rpos_q;  rones_d = rones_q;
    bwin_d = bwin_q;  bzero_d = bzero_q;  blue_d = blue_q;
    yel_d = yel_q;  ycnt_d = ycnt_q;  yzero_d = yzero_q;  fhist_d = fhist_q;
    erun_d = erun_q;  eblk_d = eblk_q;  ehits_d = ehits_q;
    scnt_d = scnt_q;  sphase_d = sphase_q;  tick_d = 1'b0;
    fsh_d = fsh_q;  fnum_d = fnum_q;  fones_d = fones_q;
    ffull_d = 1'b0;  fmatch_d = 1'b0;  fabort_d = 1'b0;
    sigchg_d = 1'b0;  sseen_d = sseen_q;  sig_we = 1'b0;
    byte_now = {fsh_q[6:0], fdl_bit};
    sec_limit = (sphase_q == SEC_THIRD) ? SEC_LONG_BITS[20:0] : SEC_SHORT_BITS[20:0];
    tx_clock_lost = (txcnt_q == TXCLK_LOSS_CYCLES[9:0]);
    if (tx_clock_in != txclk_q) begin
      txcnt_d = '0;
    end else if (!tx_clock_lost) begin
      txcnt_d = txcnt_q + 10'h001;
    end
    if (rx_bit_en) begin
      zrun_d = bit_one ? 8'h00 : zrun_q + 8'h01;
      if (!red_q && !bit_one && zrun_q == 8'(RED_SET_ZEROS - 1)) begin
        red_d = 1'b1;
        rclr_d = 1'b0;
      end
      // Ones density window opened by first one
      // Clear as soon as the fourteenth one lands inside the window
      if (red_q && rclr_q) begin
        rpos_d = rpos_q + 7'h01;
        rones_d = rones_q + {4'h0, bit_one};
        if (rones_d >= 5'(RED_CLEAR_ONES)) begin
          red_d = 1'b0;
          rclr_d = 1'b0;
          zrun_d = 8'h00;
        end else if (rpos_q == 7'(RED_CLEAR_WINDOW - 1)) begin
          rclr_d = 1'b0;
        end
      end else if (red_q && bit_one) begin
        rclr_d = 1'b1;
        rpos_d = 7'h01;
        rones_d = 5'h01;
      end
      // Back-to-back windows; zero count saturates at six
      if (!bit_one && bzero_q != 3'h6) begin
        bzero_d = bzero_q + 3'h1;
      end
      bwin_d = bwin_q + 13'h0001;
      if (bwin_q == 13'(BLUE_WINDOW_BITS - 1)) begin
        // Set on five or fewer, clear on six or more
        blue_d = (bzero_d <= 3'(BLUE_SET_MAX_ZEROS));
        bwin_d = '0;
        bzero_d = '0;
      end
      scnt_d = scnt_q + 21'h000001;
      if (scnt_q == sec_limit - 21'h000001) begin
        scnt_d = '0;
        tick_d = 1'b1;
        case (sphase_q)
          SEC_FIRST:  sphase_d = SEC_SECOND;
          SEC_SECOND: sphase_d = SEC_THIRD;
          SEC_THIRD:  sphase_d = SEC_FIRST;
          default:    sphase_d = SEC_FIRST;
        endcase
      end
    end
    if (!esf_mode && !yellow_mode_select && chan_bit_en) begin
      ycnt_d = ycnt_q + 8'h01;
      yzero_d = yzero_q + {8'h00, !chan_bit2};
      if (ycnt_q == 8'(YEL_WINDOW - 1)) begin
        yel_d = (yzero_d >= 9'(YEL_MIN_ZEROS));
        yzero_d = '0;
      end
    end
    if (!esf_mode && yellow_mode_select && fbit12_en) begin
      fhist_d = {fhist_q[0], fbit12};
      if (fhist_d == 2'b11) begin
        yel_d = 1'b1;
      end else if (fhist_d == 2'b00) begin
        yel_d = 1'b0;
      end
    end
    if (esf_mode && fdl_pattern_en) begin
      if (!yel_q) begin
        // Sixteen 00FF patterns in a row
        erun_d = fdl_pattern_00ff ? erun_q + 5'h01 : 5'h00;
        if (erun_d == 5'(ESF_SET_RUN)) begin
          yel_d = 1'b1;
          erun_d = '0;
          eblk_d = '0;
          ehits_d = '0;
        end
      end else begin
        // Clear on 14 or fewer of 16
        eblk_d = eblk_q + 4'h1;
        ehits_d = ehits_q + {4'h0, fdl_pattern_00ff};
        if (eblk_q == 4'(ESF_SET_RUN - 1)) begin
          if (ehits_d <= 5'(ESF_CLEAR_MAX)) begin
            yel_d = 1'b0;
          end
          ehits_d = '0;
        end
      end
    end
    if (fdl_bit_en) begin
      fsh_d = byte_now;
      fnum_d = fnum_q + 3'h1;
      // Byte complete, compare both match values
      if (fnum_q == 3'(FDL_BYTE_BITS - 1)) begin
        ffull_d = 1'b1;
        fmatch_d = (byte_now == link_match_reg_a) || (byte_now == link_match_reg_b);
      end
      // Abort on the eighth one in a row
      fones_d = !fdl_bit ? 4'h0 : (fones_q == 4'(ABORT_ONES)) ? fones_q : fones_q + 4'h1;
      fabort_d = fdl_bit && (fones_q == 4'(ABORT_ONES - 1));
    end
    // Compare against last signaling seen on the channel
    if (chan_sig_en && chan_index < 5'(T1_CHANNELS)) begin
      sig_we = 1'b1;
      sseen_d[chan_index] = 1'b1;
      sigchg_d = sseen_q[chan_index] && (sig_mem[chan_index] != chan_sig);
    end
  end

  // Detector registers; signaling history needs no reset thanks to sseen_q
  always_ff @(posedge ref_clk) begin
    if (sig_we) begin
      sig_mem[chan_index] <= chan_sig;
    end
    if (!resetn) begin
      txclk_q <= 1'b0;  txcnt_q <= '0;
      zrun_q <= '0;  red_q <= 1'b0;  rclr_q <= 1'b0;  rpos_q <= '0;  rones_q <= '0;
      bwin_q <= '0;  bzero_q <= '0;  blue_q <= 1'b0;
      yel_q <= 1'b0;  ycnt_q <= '0;  yzero_q <= '0;  fhist_q <= 2'b00;
      erun_q <= '0;  eblk_q <= '0;  ehits_q <= '0;
      scnt_q <= '0;  sphase_q <= SEC_FIRST;  tick_q <= 1'b0;
      fsh_q <= '0;  fnum_q <= '0;  fones_q <= '0;
      ffull_q <= 1'b0;  fmatch_q <= 1'b0;  fabort_q <= 1'b0;
      sigchg_q <= 1'b0;  sseen_q <= '0;
    end else begin
      txclk_q <= txclk_d;  txcnt_q <= txcnt_d;
      zrun_q <= zrun_d;  red_q <= red_d;  rclr_q <= rclr_d;
      rpos_q <= rpos_d;  rones_q <= rones_d;
      bwin_q <= bwin_d;  bzero_q <= bzero_d;  blue_q <= blue_d;
      yel_q <= yel_d;  ycnt_q <= ycnt_d;  yzero_q <= yzero_d;  fhist_q <= fhist_d;
      erun_q <= erun_d;  eblk_q <= eblk_d;  ehits_q <= ehits_d;
      scnt_q <= scnt_d;  sphase_q <= sphase_d;  tick_q <= tick_d;
      fsh_q <= fsh_d;  fnum_q <= fnum_d;  fones_q <= fones_d;
      ffull_q <= ffull_d;  fmatch_q <= fmatch_d;  fabort_q <= fabort_d;
      sigchg_q <= sigchg_d;  sseen_q <= sseen_d;
    end
  end

  // Host side state
  logic [7:0] line_lvl_q, line_lvl_d;
  logic [7:0] line_pend_q, line_pend_d;
  logic [7:0] evt_q, evt_d;
  logic [7:0] mask1_q, mask1_d;
  logic [7:0] mask2_q, mask2_d;
  logic [7:0] rdata_q, rdata_d;
  logic       int_n_q, int_n_d;
  logic       lpin_q, lpin_d;
  logic       fallback_q, fallback_d;
  logic [7:0] line_now;
  logic [7:0] line_set;
  logic [7:0] evt_set;

  // Status, masks, interrupt and read port
  always_comb begin
    // Live levels; slip position carries no level
    line_now = {loop_up_match, loop_down_match, tx_clock_lost, 1'b0,
                blue_q, yel_q, red_q, !framer_in_sync};
    line_lvl_d = line_now;
    // Alarms flag any change, others only a rising edge
    line_set = ((line_now ^ line_lvl_q) & ALARM_BITS) | (line_now & ~line_lvl_q & ~ALARM_BITS);
    line_set[SLIP_BIT] = slip_event;
    evt_set = {rx_mf_boundary, tx_mf_boundary, tick_q, ffull_q,
               tx_link_drained, fmatch_q, fabort_q, sigchg_q};
    line_pend_d = line_pend_q;
    evt_d = evt_q;
    mask1_d = mask1_q;
    mask2_d = mask2_q;
    rdata_d = RDATA_UNMAPPED;
    if (cpu_rd) begin
      case (cpu_addr)
        LINE_ALARM_STATUS_ADDR: begin
          rdata_d = {line_lvl_q[7:5], line_pend_q[SLIP_BIT], line_lvl_q[3:0]};
          line_pend_d = '0;
        end
        EVENT_STATUS_ADDR: begin
          rdata_d = evt_q;
          evt_d = '0;
        end
        LINE_MASK_ADDR:  rdata_d = mask1_q;
        EVENT_MASK_ADDR: rdata_d = mask2_q;
        default:         rdata_d = RDATA_UNMAPPED;
      endcase
    end
    if (cpu_wr && cpu_addr == LINE_MASK_ADDR) begin
      mask1_d = cpu_wdata;
    end
    if (cpu_wr && cpu_addr == EVENT_MASK_ADDR) begin
      mask2_d = cpu_wdata;
    end
    // New causes win over a read that clears
    line_pend_d = line_pend_d | line_set;
    evt_d = evt_d | evt_set;
    // Mask one lets a cause through
    int_n_d = !(|(line_pend_d & mask1_d) || |(evt_d & mask2_d));
    lpin_d = loss_pin_select ? tx_clock_lost : !framer_in_sync;
    fallback_d = tx_clock_fallback_enable && tx_clock_lost;
  end

  // Host side registers; interrupt held released throughout reset
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      line_lvl_q <= '0;
      line_pend_q <= '0;
      evt_q <= '0;
      mask1_q <= MASK_RESET;
      mask2_q <= MASK_RESET;
      rdata_q <= RDATA_UNMAPPED;
      int_n_q <= 1'b1;
      lpin_q <= 1'b0;
      fallback_q <= 1'b0;
    end else begin
      line_lvl_q <= line_lvl_d;
      line_pend_q <= line_pend_d;
      evt_q <= evt_d;
      mask1_q <= mask1_d;
      mask2_q <= mask2_d;
      rdata_q <= rdata_d;
      int_n_q <= int_n_d;
      lpin_q <= lpin_d;
      fallback_q <= fallback_d;
    end
  end

  assign cpu_rdata = rdata_q;
  assign int_n = int_n_q;
  assign loss_indicator_pin = lpin_q;
  assign tx_clock_use_recovered = fallback_q;

endmodule

// file: t1_alarm_monitor.sv
module t1_alarm_monitor (
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic [7:0] cpu_addr,
  input wire logic       cpu_rd,
  input wire logic [7:0] cpu_rdata,
  input wire logic       framer_in_sync,
  input wire logic       slip_event,
  input wire logic       rx_mf_boundary,
  input wire logic       loop_up_match,
  input wire logic       tx_clock_in,
  input wire logic       loss_pin_select,
  input wire logic       tx_clock_fallback_enable,
  input wire logic       loss_indicator_pin,
  input wire logic       tx_clock_use_recovered
);
  import t1_alarm_pkg::*;
  logic [9:0] quiet_q;
  logic [9:0] quiet_d;
  logic [1:0] seen_q;
  logic [1:0] seen_d;
  logic       last_q;
  logic       rd20;
  logic       rd21;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // Status reads decoded once
  assign rd20 = cpu_rd && cpu_addr == LINE_ALARM_STATUS_ADDR;
  assign rd21 = cpu_rd && cpu_addr == EVENT_STATUS_ADDR;

  // Quiet run saturates so a long stop never wraps back to zero
  always_comb begin
    quiet_d = quiet_q + {9'h000, quiet_q != 10'h3FF};
    if (tx_clock_in != last_q) begin
      quiet_d = 10'h000;
    end
    seen_d = (seen_q & ~{rd21, rd20}) | {rx_mf_boundary, slip_event};
  end

  // Helper state
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      quiet_q <= 10'h000;
      seen_q  <= 2'b00;
    end else begin
      quiet_q <= quiet_d;
      seen_q  <= seen_d;
    end
    last_q <= tx_clock_in;
  end

  a_loopup_read: assert property (loop_up_match[*3] ##0 rd20 |=> cpu_rdata[LUP_BIT])
    else $error("loop-up level missing from status read");
  a_sync_lost_read: assert property ((!framer_in_sync)[*3] ##0 rd20 |=> cpu_rdata[0])
    else $error("sync loss missing from status read");
  a_slip_sticky: assert property (rd20 && seen_q[0] && $past(seen_q[0]) |=> cpu_rdata[4])
    else $error("unread slip not reported");
  a_rmf_sticky: assert property (rd21 && seen_q[1] && $past(seen_q[1]) |=> cpu_rdata[7])
    else $error("unread multiframe not reported");
  a_pin_sync: assert property ((!loss_pin_select && !framer_in_sync)[*3] |-> loss_indicator_pin)
    else $error("pin low during sync loss");
  a_txloss_pin: assert property ((loss_pin_select && quiet_q > 10'h20C)[*6] |-> loss_indicator_pin)
    else $error("pin low after transmit clock stopped");
  a_txok_pin: assert property ((loss_pin_select && quiet_q < 10'h1F4)[*6] |-> !loss_indicator_pin)
    else $error("pin high while transmit clock runs");
  a_fallback_off: assert property ((!tx_clock_fallback_enable)[*2] |-> !tx_clock_use_recovered)
    else $error("fallback active while disabled");
  a_fallback_on: assert property
    ((tx_clock_fallback_enable && quiet_q > 10'h20C)[*6] |-> tx_clock_use_recovered)
    else $error("no fallback after transmit clock loss");
endmodule

bind t1_alarm_status_flags t1_alarm_monitor u_mon (
  .ref_clk, .resetn, .cpu_addr, .cpu_rd, .cpu_rdata, .framer_in_sync, .slip_event,
  .rx_mf_boundary, .loop_up_match, .tx_clock_in, .loss_pin_select,
  .tx_clock_fallback_enable, .loss_indicator_pin, .tx_clock_use_recovered
);

// file: t1_host_model.sv
module t1_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] cpu_rdata,
  output logic      [7:0] cpu_addr,
  output logic            cpu_rd,
  output logic            cpu_wr,
  output logic      [7:0] cpu_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bus idle from time zero
  initial begin
    cpu_addr  = 8'h00;
    cpu_rd    = 1'b0;
    cpu_wr    = 1'b0;
    cpu_wdata = 8'h00;
  end

  // One-cycle write strobe; a trailing edge keeps two calls off one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cpu_addr  <= a;
    cpu_wdata <= d;
    cpu_wr    <= 1'b1;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Read data stands one cycle after the taking edge; taken at the next edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    cpu_addr <= a;
    cpu_rd   <= 1'b1;
    @(posedge ref_clk);
    cpu_rd <= 1'b0;
    @(posedge ref_clk);
    d = cpu_rdata;
  endtask

  function automatic logic blue_ok(input logic [7:0] s);
    return s[3] & ~s[0];
  endfunction
endmodule

// file: tb_t1_alarm_status_flags.sv
module tb_t1_alarm_status_flags;
  timeunit 1ns;
  timeprecision 1ps;
  import t1_alarm_pkg::*;
  logic       ref_clk, resetn, cpu_rd, cpu_wr, int_n, tx_clock_in, tx_run;
  logic       framer_in_sync, loop_up_match, loop_down_match, loss_pin_select;
  logic       tx_clock_fallback_enable, yellow_mode_select, esf_mode;
  logic       loss_indicator_pin, tx_clock_use_recovered;
  logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, link_match_reg_a, link_match_reg_b, dat;
  logic [9:0] stb;
  int         n_fail;
  int         checks_done;

  t1_host_model host (.ref_clk, .cpu_rdata, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata);

  // Short windows keep the run brief
  t1_alarm_status_flags #(.BLUE_WINDOW_BITS(16), .SEC_SHORT_BITS(20), .SEC_LONG_BITS(23)) DUT (
    .ref_clk, .resetn, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata, .int_n,
    .rx_bit_en(stb[9]), .rx_positive_rail_in(dat[0]), .rx_negative_rail_in(dat[1]),
    .framer_in_sync, .slip_event(stb[0]), .rx_mf_boundary(stb[1]), .tx_mf_boundary(stb[2]),
    .loop_up_match, .loop_down_match, .tx_clock_in, .loss_pin_select,
    .tx_clock_fallback_enable, .yellow_mode_select, .esf_mode, .chan_bit_en(stb[4]),
    .chan_bit2(dat[0]), .chan_sig_en(stb[8]), .chan_index({1'b0, dat[7:4]}),
    .chan_sig(dat[3:0]), .fbit12_en(stb[5]), .fbit12(dat[0]), .fdl_bit_en(stb[6]),
    .fdl_bit(dat[0]), .fdl_pattern_en(stb[7]), .fdl_pattern_00ff(dat[0]),
    .link_match_reg_a, .link_match_reg_b, .tx_link_drained(stb[3]),
    .loss_indicator_pin, .tx_clock_use_recovered
  );

  // Clock and a free-running transmit clock that can be stopped
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (tx_run) tx_clock_in <= ~tx_clock_in;

  task automatic end_sim;
    if (n_fail == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      n_fail++;
    end
  endtask

  // Settling gap covers the two-stage lag of internal detectors (detector register, then status register)
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    repeat (4) @(posedge ref_clk);
    host.rd(a, d);
    chk(d, exp);
  endtask

  // One-cycle pulse on strobe k with its data; a gap cycle follows
  task automatic strobe(input int k, input logic [7:0] d);
    stb <= 10'h001 << k;
    dat <= d;
    @(posedge ref_clk);
    stb <= 10'h000;
    @(posedge ref_clk);
  endtask

  task automatic wait_int(input logic v);
    int i;
    i = 0;
    while (int_n !== v && i < 8) begin
      @(posedge ref_clk);
      i++;
    end
    chk({7'h00, int_n}, {7'h00, v});
    if (int_n !== v) end_sim();
  endtask

  task automatic t_regs;
    rdc(LINE_MASK_ADDR, MASK_RESET);
    rdc(EVENT_MASK_ADDR, MASK_RESET);
    host.wr(LINE_ALARM_STATUS_ADDR, 8'hFF);
    host.wr(8'h55, 8'hFF);
    rdc(LINE_ALARM_STATUS_ADDR, 8'h00);
    rdc(8'h55, RDATA_UNMAPPED);
    host.wr(LINE_MASK_ADDR, 8'hA5);
    rdc(LINE_MASK_ADDR, 8'hA5);
    host.wr(LINE_MASK_ADDR, MASK_RESET);
  endtask

  task automatic t_events;
    strobe(1, 8'h00);
    strobe(2, 8'h00);
    strobe(3, 8'h00);
    rdc(EVENT_STATUS_ADDR, 8'hC8);
    rdc(EVENT_STATUS_ADDR, 8'h00);
    strobe(0, 8'h00);
    rdc(LINE_ALARM_STATUS_ADDR, 8'h10);
  endtask

  // Pending event held back by its mask, then released by it
  task automatic t_int;
    host.wr(EVENT_MASK_ADDR, 8'h40);
    strobe(1, 8'h00);
    repeat (6) @(posedge ref_clk);
    chk({7'h00, int_n}, 8'h01);
    host.wr(EVENT_MASK_ADDR, 8'h80);
    wait_int(1'b0);
    rdc(EVENT_STATUS_ADDR, 8'h80);
    wait_int(1'b1);
    host.wr(LINE_MASK_ADDR, 8'h01);
    framer_in_sync <= 1'b0;
    wait_int(1'b0);
    rdc(LINE_ALARM_STATUS_ADDR, 8'h01);
    wait_int(1'b1);
    framer_in_sync <= 1'b1;
    wait_int(1'b0);
    rdc(LINE_ALARM_STATUS_ADDR, 8'h00);
    wait_int(1'b1);
    host.wr(LINE_MASK_ADDR, MASK_RESET);
    host.wr(EVENT_MASK_ADDR, MASK_RESET);
  endtask

  task automatic t_levels;
    loop_up_match   <= 1'b1;
    loop_down_match <= 1'b1;
    rdc(LINE_ALARM_STATUS_ADDR, 8'hC0);
    loop_up_match   <= 1'b0;
    loop_down_match <= 1'b0;
    rdc(LINE_ALARM_STATUS_ADDR, 8'h00);
  endtask

  task automatic t_txloss;
    loss_pin_select          <= 1'b1;
    tx_clock_fallback_enable <= 1'b1;
    tx_run                   <= 1'b0;
    repeat (505) @(posedge ref_clk);
    chk({6'h00, loss_indicator_pin, tx_clock_use_recovered}, 8'h00);
    repeat (25) @(posedge ref_clk);
    chk({6'h00, loss_indicator_pin, tx_clock_use_recovered}, 8'h03);
    rdc(LINE_ALARM_STATUS_ADDR, 8'h20);
    tx_run <= 1'b1;
    rdc(LINE_ALARM_STATUS_ADDR, 8'h00);
    chk({6'h00, loss_indicator_pin, tx_clock_use_recovered}, 8'h00);
    loss_pin_select          <= 1'b0;
    tx_clock_fallback_enable <= 1'b0;
  endtask

  // Each mode at its boundary count
  task automatic t_yellow;
    for (int i = 0; i < 256; i++) strobe(4, {7'h00, i >= 254});
    rdc(LINE_ALARM_STATUS_ADDR, 8'h04);
    for (int i = 0; i < 256; i++) strobe(4, {7'h00, i >= 253});
    rdc(LINE_ALARM_STATUS_ADDR, 8'h00);
    yellow_mode_select <= 1'b1;
    strobe(5, 8'h01);
    strobe(5, 8'h01);
    strobe(5, 8'h00);
    rdc(LINE_ALARM_STATUS_ADDR, 8'h04);
    strobe(5, 8'h00);
    rdc(LINE_ALARM_STATUS_ADDR, 8'h00);
    esf_mode <= 1'b1;
    for (int i = 0; i < 16; i++) strobe(7, 8'h01);
    rdc(LINE_ALARM_STATUS_ADDR, 8'h04);
    for (int i = 0; i < 16; i++) strobe(7, {7'h00, i >= 2});
    rdc(LINE_ALARM_STATUS_ADDR, 8'h00);
    esf_mode <= 1'b0;
  endtask

  // Line bits: blue windows, carrier loss and the tick at bit 272
  task automatic t_line;
    logic [7:0] d;
    for (int i = 0; i < 40; i++) strobe(9, 8'h01);
    rdc(LINE_ALARM_STATUS_ADDR, 8'h08);
    for (int i = 0; i < 191; i++) strobe(9, 8'h00);
    rdc(LINE_ALARM_STATUS_ADDR, 8'h00);
    strobe(9, 8'h00);
    rdc(LINE_ALARM_STATUS_ADDR, 8'h02);
    for (int i = 0; i < 13; i++) strobe(9, 8'h02);
    rdc(LINE_ALARM_STATUS_ADDR, 8'h02);
    strobe(9, 8'h01);
    rdc(LINE_ALARM_STATUS_ADDR, 8'h00);
    for (int i = 0; i < 20; i++) strobe(9, 8'h01);
    host.rd(LINE_ALARM_STATUS_ADDR, d);
    chk(d, 8'h08);
    chk({7'h00, host.blue_ok(d)}, 8'h01);
    rdc(EVENT_STATUS_ADDR, 8'h20);
    for (int i = 0; i < 5; i++) strobe(9, 8'h01);
    rdc(EVENT_STATUS_ADDR, 8'h00);
    strobe(9, 8'h01);
    rdc(EVENT_STATUS_ADDR, 8'h20);
  endtask

  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) strobe(6, {7'h00, b[i]});
  endtask

  task automatic t_link;
    link_match_reg_a <= 8'hFF;
    link_match_reg_b <= 8'h5A;
    send_byte(8'hFF);
    rdc(EVENT_STATUS_ADDR, 8'h16);
    send_byte(8'h5A);
    rdc(EVENT_STATUS_ADDR, 8'h14);
    send_byte(8'h33);
    rdc(EVENT_STATUS_ADDR, 8'h10);
  endtask

  task automatic t_sig;
    strobe(8, 8'h35);
    strobe(8, 8'h35);
    rdc(EVENT_STATUS_ADDR, 8'h00);
    strobe(8, 8'h3A);
    rdc(EVENT_STATUS_ADDR, 8'h01);
  endtask

  // Reset for two cycles, then each scenario in turn
  initial begin
    {resetn, tx_clock_in, loop_up_match, loop_down_match, loss_pin_select} = 5'h00;
    {tx_clock_fallback_enable, yellow_mode_select, esf_mode} = 3'h0;
    {tx_run, framer_in_sync} = 2'h3;
    {link_match_reg_a, link_match_reg_b, dat, stb} = 34'h0;
    n_fail      = 0;
    checks_done = 0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_events();
    t_int();
    t_levels();
    t_txloss();
    t_yellow();
    t_line();
    t_link();
    t_sig();
    end_sim();
  end
endmodule
